// *** common/tws_defines.svh ***
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
// Register offsets in I/O space.
`define TWS_ADDR_STATUS 6'h01
`define TWS_ADDR_OWN 6'h02
`define TWS_ADDR_DATA 6'h03
// Reset values.
`define TWS_OWN_RST 8'h7f
`define TWS_DATA_RST 8'hff
`define TWS_PS_RST 2'h0
// Status codes, bits 7:3 of the status register.
`define TWS_ST_NONE 5'h1f
`define TWS_ST_SLA_W 5'h0c
`define TWS_ST_GC 5'h0e
`define TWS_ST_RX_ACK 5'h10
`define TWS_ST_RX_NACK 5'h11
`define TWS_ST_GC_ACK 5'h12
`define TWS_ST_GC_NACK 5'h13
`define TWS_ST_STOP 5'h14
`define TWS_ST_SLA_R 5'h15
`define TWS_ST_TX_ACK 5'h17
`define TWS_ST_TX_NACK 5'h18
// Field positions.
`define TWS_GCE_BIT 0
`define TWS_SLA_HI 7
`define TWS_SLA_LO 1
// Bus addresses and bit counts.
`define TWS_GCALL 8'h00
`define TWS_CNT_ACK 4'd8
`define TWS_CNT_DONE 4'd9
`define TWS_CNT_ZERO 4'd0
// Prescale factors.
`define TWS_PSF_1 7'd1
`define TWS_PSF_4 7'd4
`define TWS_PSF_16 7'd16
`define TWS_PSF_64 7'd64
`endif

// *** common/tws_pkg.sv ***
package tws_pkg;
   typedef enum logic [2:0] {
      TWS_IDLE = 3'b000,
      TWS_ADDR = 3'b001,
      TWS_RX = 3'b010,
      TWS_TX = 3'b011,
      TWS_HOLD = 3'b100,
      TWS_IGN = 3'b101
   } tws_state_t;

   typedef struct packed {
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tws_io_req_t;
endpackage : tws_pkg

// *** verilog/tws_core.sv ***
// Functional notes
// - Status register reads five-bit bus code in 7:3, prescaler in 1:0.
// - Prescaler bits read/write; select factor 1, 4, 16 or 64.
// - Data register holds byte to send, or last byte received.
// - Data register writes only take effect while job flag is set.
// - Data register stays stable while the job flag stays set.
// - Bus bits shift in while shifting out; register holds last byte.
// - Data contents undefined after wake by interface interrupt.
// - Arbitration loss to slave mode keeps shifted data intact.
// - Acknowledge bit is generated and sampled by hardware only.
// - Own-address bits 7:1 hold slave address, used in slave modes.
// - Own-address bit 0 enables general call address recognition.
// - Comparator matches own or general call address, raising request.
// - Job flag set at job end, stretches SCL, write-one clears.
// - Data write with flag low sets collision; with flag high clears.
// - Acknowledge own address, enabled general call, received data.
`include "tws_defines.svh"

module tws_core
   import tws_pkg::*;
#(
   parameter int DEPTH = 2
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port.
   input wire tws_io_req_t i_io,
   output logic [7:0] o_io_rdata,
   // Control logic side.
   input wire logic i_ack_generate_enable,
   input wire logic i_job_clear,
   output logic o_job_complete_flag,
   output logic o_write_collision_flag,
   output logic o_addr_match,
   output logic [6:0] o_rate_prescale_factor,
   // Bus pins.
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_out,
   output logic o_scl_oe,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Received byte stream.
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
   logic rise, fall, start, stop, hit;
   tws_state_t st_q, st_d, nx_q, nx_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, own_q, own_d, pdat_q, pdat_d, rdata_q, rdata_d;
   logic [4:0] code_q, code_d;
   logic [1:0] ps_q, ps_d;
   logic flag_q, flag_d, flag_set, wc_q, wc_d, match_q, match_d;
   logic drv_q, drv_d, gc_q, gc_d, nack_q, nack_d, pend_q, pend_d;
   logic [7:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [CW-1:0] fc_q, fc_d;
   logic in_ready, push, pop;

   // Pins cross in through two flops; edges use the second and third.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= i_scl;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= i_sda;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   assign rise = scl_s_q & ~scl_p_q;
   assign fall = ~scl_s_q & scl_p_q;
   assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
   assign hit = (sh_q[`TWS_SLA_HI:`TWS_SLA_LO] ==
                 own_q[`TWS_SLA_HI:`TWS_SLA_LO]) |
                (own_q[`TWS_GCE_BIT] & (sh_q == `TWS_GCALL));

   always_comb begin
      st_d = st_q;
      nx_d = nx_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      drv_d = drv_q;
      code_d = code_q;
      gc_d = gc_q;
      nack_d = nack_q;
      pdat_d = pdat_q;
      pend_d = pend_q & ~in_ready;
      flag_set = 1'b0;
      match_d = 1'b0;
      wc_d = wc_q;
      own_d = own_q;
      ps_d = ps_q;
      unique case (st_q)
         TWS_IDLE, TWS_IGN: begin
         end
         TWS_ADDR, TWS_RX, TWS_TX: begin
            if (rise) begin
               cnt_d = cnt_q + 4'd1;
               // The bus is sampled even while driving, so the register
               // keeps what was really on the wire.
               if (cnt_q < `TWS_CNT_ACK) begin
                  sh_d = {sh_q[6:0], sda_s_q};
               end else begin
                  nack_d = sda_s_q;
               end
            end
            if (fall && cnt_q == `TWS_CNT_ACK) begin
               unique case (st_q)
                  TWS_ADDR: begin
                     if (hit && i_ack_generate_enable) begin
                        drv_d = 1'b1;
                        gc_d = (sh_q == `TWS_GCALL);
                     end else begin
                        drv_d = 1'b0;
                        st_d = TWS_IGN;
                     end
                  end
                  TWS_RX: drv_d = i_ack_generate_enable;
                  default: drv_d = 1'b0;
               endcase
            end else if (fall && cnt_q == `TWS_CNT_DONE) begin
               drv_d = 1'b0;
               flag_set = 1'b1;
               st_d = TWS_HOLD;
               unique case (st_q)
                  TWS_ADDR: begin
                     match_d = 1'b1;
                     nx_d = sh_q[0] ? TWS_TX : TWS_RX;
                     code_d = gc_q ? `TWS_ST_GC :
                              (sh_q[0] ? `TWS_ST_SLA_R : `TWS_ST_SLA_W);
                  end
                  TWS_RX: begin
                     pend_d = 1'b1;
                     pdat_d = sh_q;
                     nx_d = drv_q ? TWS_RX : TWS_IGN;
                     if (gc_q) begin
                        code_d = drv_q ? `TWS_ST_GC_ACK : `TWS_ST_GC_NACK;
                     end else begin
                        code_d = drv_q ? `TWS_ST_RX_ACK : `TWS_ST_RX_NACK;
                     end
                  end
                  default: begin
                     nx_d = nack_q ? TWS_IGN : TWS_TX;
                     code_d = nack_q ? `TWS_ST_TX_NACK : `TWS_ST_TX_ACK;
                  end
               endcase
            end else if (fall && st_q == TWS_TX && cnt_q < `TWS_CNT_ACK) begin
               drv_d = ~sh_q[7];
            end
         end
         TWS_HOLD: begin
            // A full buffer keeps SCL low, so a slow reader loses nothing.
            if (!flag_q && !pend_q) begin
               st_d = nx_q;
               cnt_d = `TWS_CNT_ZERO;
               drv_d = (nx_q == TWS_TX) & ~sh_q[7];
               code_d = `TWS_ST_NONE;
            end
         end
         default: st_d = TWS_IDLE;
      endcase
      if (stop) begin
         drv_d = 1'b0;
         if (st_q == TWS_RX) begin
            flag_set = 1'b1;
            code_d = `TWS_ST_STOP;
            st_d = TWS_HOLD;
            nx_d = TWS_IDLE;
         end else if (st_q != TWS_HOLD) begin
            st_d = TWS_IDLE;
         end
      end else if (start && st_q != TWS_HOLD) begin
         st_d = TWS_ADDR;
         cnt_d = `TWS_CNT_ZERO;
         drv_d = 1'b0;
         gc_d = 1'b0;
      end
      // The job flag gives the data register write access; otherwise that write is dropped.
      // Contents after a wake from sleep are not guaranteed.
      if (i_io.wr) begin
         unique case (i_io.addr)
            `TWS_ADDR_STATUS: ps_d = i_io.wdata[1:0];
            `TWS_ADDR_OWN: own_d = i_io.wdata;
            `TWS_ADDR_DATA: begin
               if (flag_q) begin
                  sh_d = i_io.wdata;
                  wc_d = 1'b0;
               end else begin
                  wc_d = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      flag_d = flag_set | (flag_q & ~i_job_clear);
      unique case (i_io.addr)
         `TWS_ADDR_STATUS: rdata_d = {code_q, 1'b0, ps_q};
         `TWS_ADDR_OWN: rdata_d = own_q;
         `TWS_ADDR_DATA: rdata_d = sh_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= TWS_IDLE;
         nx_q <= TWS_IDLE;
         cnt_q <= `TWS_CNT_ZERO;
         sh_q <= `TWS_DATA_RST;
         own_q <= `TWS_OWN_RST;
         pdat_q <= 8'h00;
         rdata_q <= 8'h00;
         code_q <= `TWS_ST_NONE;
         ps_q <= `TWS_PS_RST;
         flag_q <= 1'b0;
         wc_q <= 1'b0;
         match_q <= 1'b0;
         drv_q <= 1'b0;
         gc_q <= 1'b0;
         nack_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         st_q <= st_d;
         nx_q <= nx_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         own_q <= own_d;
         pdat_q <= pdat_d;
         rdata_q <= rdata_d;
         code_q <= code_d;
         ps_q <= ps_d;
         flag_q <= flag_d;
         wc_q <= wc_d;
         match_q <= match_d;
         drv_q <= drv_d;
         gc_q <= gc_d;
         nack_q <= nack_d;
         pend_q <= pend_d;
      end
   end

   // Two-entry buffer between the shifter and the byte stream.
   assign in_ready = (fc_q != CW'(DEPTH));
   assign push = pend_q & in_ready;
   assign pop = o_rx_valid & i_rx_ready;
   assign o_rx_valid = (fc_q != '0);
   assign o_rx_data = mem_q[rp_q];

   always_comb begin
      wp_d = push ? ((wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
      rp_d = pop ? ((rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
      fc_d = fc_q + CW'(push) - CW'(pop);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wp_q <= '0;
         rp_q <= '0;
         fc_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         fc_q <= fc_d;
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_mem
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            mem_q[g] <= 8'h00;
         end else if (push && wp_q == PW'(g)) begin
            mem_q[g] <= pdat_q;
         end
      end
   end

   always_comb begin
      unique case (ps_q)
         2'h0: o_rate_prescale_factor = `TWS_PSF_1;
         2'h1: o_rate_prescale_factor = `TWS_PSF_4;
         2'h2: o_rate_prescale_factor = `TWS_PSF_16;
         default: o_rate_prescale_factor = `TWS_PSF_64;
      endcase
   end

   assign o_io_rdata = rdata_q;
   assign o_job_complete_flag = flag_q;
   assign o_write_collision_flag = wc_q;
   assign o_addr_match = match_q;
   assign o_scl_out = 1'b0;
   assign o_scl_oe = flag_q | pend_q;
   assign o_sda_out = 1'b0;
   assign o_sda_oe = drv_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_status_read: assert property (
      i_io.addr == `TWS_ADDR_STATUS |=> o_io_rdata ==
         {$past(code_q), 1'b0, $past(ps_q)})
      else $error("status read mismatch");
   a_prescale_map: assert property (
      i_io.wr && i_io.addr == `TWS_ADDR_STATUS && i_io.wdata[1:0] == 2'h3
      |=> o_rate_prescale_factor == `TWS_PSF_64)
      else $error("prescale factor wrong");
   a_data_blocked: assert property (
      i_io.wr && i_io.addr == `TWS_ADDR_DATA && !flag_q && st_q == TWS_IDLE
      |=> o_write_collision_flag && $stable(sh_q))
      else $error("data write not blocked");
   a_data_stable: assert property (
      flag_q && $past(flag_q) && !$past(i_io.wr) |-> $stable(sh_q))
      else $error("data changed under flag");
   a_flag_stretch: assert property (
      flag_q && !i_job_clear |=> flag_q && o_scl_oe)
      else $error("flag dropped or SCL released");
   a_match_flag: assert property (
      $rose(o_addr_match) |-> o_job_complete_flag ##1 !o_addr_match)
      else $error("match without flag");
   a_wc_clear: assert property (
      i_io.wr && i_io.addr == `TWS_ADDR_DATA && flag_q
      |=> !o_write_collision_flag && sh_q == $past(i_io.wdata))
      else $error("collision not cleared");
   a_own_ack: assert property (
      st_q == TWS_ADDR && fall && cnt_q == `TWS_CNT_ACK && hit &&
      i_ack_generate_enable && !start && !stop |=> o_sda_oe [*1])
      else $error("own address not acked");

   c_addr_match: cover property (o_addr_match);
   c_rx_push: cover property (push ##1 o_rx_valid);
   c_collision: cover property ($rose(o_write_collision_flag));
   c_tx_mode: cover property (st_q == TWS_TX ##[1:1000] flag_q);
endmodule : tws_core

// *** dv/tws_bus_master.sv ***
module tws_bus_master (
   // Clock.
   input wire logic i_clk,
   // Resolved bus lines and this master's pull-downs.
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_low,
   output logic o_sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask : half
   // A slave may stretch the low phase, so wait for SCL to go high.
   task automatic rise();
      int n;
      n = 0;
      o_scl_low <= 1'b0;
      @(posedge i_clk);
      // The bench's cycle ceiling is lower, so a stuck line ends as a fail.
      while (i_scl !== 1'b1 && n < 30000) begin
         n++;
         @(posedge i_clk);
      end
      // Three more edges give a high phase of four clocks, like the low one.
      repeat (3) @(posedge i_clk);
   endtask : rise
   task automatic start();
      o_sda_low <= 1'b1;
      half();
      o_scl_low <= 1'b1;
      half();
   endtask : start
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         o_sda_low <= ~b[i];
         half();
         rise();
         o_scl_low <= 1'b1;
      end
      o_sda_low <= 1'b0;
      half();
      rise();
      ack = i_sda;
      o_scl_low <= 1'b1;
      half();
   endtask : send
   // Reads one byte from the slave, then answers with the given acknowledge.
   task automatic recv(input logic nack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_sda_low <= 1'b0;
         half();
         rise();
         b[i] = i_sda;
         o_scl_low <= 1'b1;
      end
      o_sda_low <= ~nack;
      half();
      rise();
      o_scl_low <= 1'b1;
      half();
   endtask : recv
   task automatic stop();
      o_sda_low <= 1'b1;
      half();
      rise();
      o_sda_low <= 1'b0;
      half();
   endtask : stop
endmodule : tws_bus_master

// *** dv/testbench.sv ***
`include "tws_defines.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
   fails++; $display("Error %s expected %h seen %h", n, e, a); end end
module testbench import tws_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, ack_en = 1'b0, jclr = 1'b0, rdy = 1'b0;
   tws_io_req_t io = '0;
   logic [7:0] rdata, rxd;
   logic [6:0] factor;
   logic flag, wc, match, scl_oe, sda_oe, scl_out, sda_out, rxv;
   logic m_scl, m_sda, ack;
   wire scl = ~(m_scl | scl_oe);
   wire sda = ~(m_sda | sda_oe);
   int fails = 0, comparisons = 0, cyc = 0, mcnt = 0;
   always #50 clk = ~clk;
   tws_core #(.DEPTH(2)) u_dut (.i_clk(clk), .i_rst(rst), .i_io(io),
      .o_io_rdata(rdata), .i_ack_generate_enable(ack_en),
      .i_job_clear(jclr), .o_job_complete_flag(flag),
      .o_write_collision_flag(wc), .o_addr_match(match),
      .o_rate_prescale_factor(factor), .i_scl(scl), .i_sda(sda),
      .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out),
      .o_sda_oe(sda_oe), .o_rx_valid(rxv), .o_rx_data(rxd),
      .i_rx_ready(rdy));
   tws_bus_master u_m (.i_clk(clk), .i_scl(scl), .i_sda(sda),
      .o_scl_low(m_scl), .o_sda_low(m_sda));
   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   // Match pulses are counted mid-cycle, once they have settled.
   always @(negedge clk) begin
      if (match === 1'b1) mcnt++;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      io <= '{1'b1, a, d};
      @(posedge clk);
      io.wr <= 1'b0;
   endtask : wr
   task automatic chk_rd(string n, logic [5:0] a, logic [7:0] e);
      @(posedge clk);
      io <= '{1'b0, a, 8'h00};
      @(posedge clk);
      @(negedge clk);
      `CHK(n, e, rdata)
   endtask : chk_rd
   // Status is compared with the prescaler bits masked off.
   task automatic chk_st(logic [7:0] e);
      @(posedge clk);
      io <= '{1'b0, `TWS_ADDR_STATUS, 8'h00};
      @(posedge clk);
      @(negedge clk);
      `CHK("status", e, rdata & 8'hf8)
   endtask : chk_st
   task automatic clr();
      @(posedge clk);
      jclr <= 1'b1;
      @(posedge clk);
      jclr <= 1'b0;
   endtask : clr
   task automatic wait_flag(logic e);
      for (int i = 0; i < 40; i++) if (flag !== 1'b1) @(negedge clk);
      `CHK("flag", e, flag)
   endtask : wait_flag
   task automatic fin();
      clr();
      u_m.stop();
      wait_flag(1'b1);
      chk_st(8'ha0);
      clr();
   endtask : fin
   task automatic t_reset();
      chk_rd("own", `TWS_ADDR_OWN, 8'h7f);
      chk_rd("data", `TWS_ADDR_DATA, 8'hff);
      chk_rd("status", `TWS_ADDR_STATUS, 8'hf8);
      chk_rd("unmapped", 6'h3f, 8'h00);
      `CHK("sda_out", 1'b0, sda_out)
      `CHK("scl_out", 1'b0, scl_out)
      `CHK("scl_oe", 1'b0, scl_oe)
   endtask : t_reset
   task automatic t_prescale();
      logic [6:0] f [4] = '{7'd1, 7'd4, 7'd16, 7'd64};
      for (int i = 0; i < 4; i++) begin
         wr(`TWS_ADDR_STATUS, 8'hfc | 8'(i));
         chk_rd("ps", `TWS_ADDR_STATUS, 8'hf8 | 8'(i));
         `CHK("factor", f[i], factor)
      end
      wr(`TWS_ADDR_STATUS, 8'h00);
   endtask : t_prescale
   task automatic t_collide();
      wr(`TWS_ADDR_DATA, 8'h12);
      @(negedge clk);
      `CHK("wc", 1'b1, wc)
      chk_rd("data", `TWS_ADDR_DATA, 8'hff);
   endtask : t_collide
   task automatic t_receive();
      logic [7:0] d [2] = '{8'ha5, 8'h5a};
      int m0;
      wr(`TWS_ADDR_OWN, 8'h54);
      ack_en <= 1'b1;
      m0 = mcnt;
      u_m.start();
      u_m.send(8'h54, ack);
      `CHK("ack", 1'b0, ack)
      wait_flag(1'b1);
      `CHK("match", 1, mcnt - m0)
      chk_st(8'h60);
      chk_rd("addr", `TWS_ADDR_DATA, 8'h54);
      `CHK("scl_oe", 1'b1, scl_oe)
      wr(`TWS_ADDR_DATA, 8'h3c);
      @(negedge clk);
      `CHK("wc", 1'b0, wc)
      chk_rd("data", `TWS_ADDR_DATA, 8'h3c);
      repeat (30) @(posedge clk);
      chk_rd("hold", `TWS_ADDR_DATA, 8'h3c);
      for (int i = 0; i < 2; i++) begin
         clr();
         u_m.send(d[i], ack);
         `CHK("ack", 1'b0, ack)
         wait_flag(1'b1);
         chk_st(8'h80);
         chk_rd("rx", `TWS_ADDR_DATA, d[i]);
      end
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         `CHK("rx_valid", 1'b1, rxv)
         `CHK("rx_data", d[i], rxd)
         @(posedge clk);
         rdy <= 1'b1;
         @(posedge clk);
         rdy <= 1'b0;
      end
      @(negedge clk);
      `CHK("rx_empty", 1'b0, rxv)
      fin();
   endtask : t_receive
   task automatic t_table();
      logic [7:0] own [4] = '{8'h54, 8'h54, 8'h54, 8'h55};
      logic [7:0] sla [4] = '{8'h56, 8'h54, 8'h00, 8'h00};
      logic en [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 4; i++) begin
         wr(`TWS_ADDR_OWN, own[i]);
         ack_en <= en[i];
         u_m.start();
         u_m.send(sla[i], ack);
         `CHK("ack", i != 3, ack)
         wait_flag(i == 3);
         if (i == 3) begin
            chk_st(8'h70);
            clr();
            u_m.send(8'hc3, ack);
            `CHK("gc_ack", 1'b0, ack)
            wait_flag(1'b1);
            chk_st(8'h90);
            @(negedge clk);
            `CHK("gc_rx", 8'hc3, rxd)
            @(posedge clk);
            rdy <= 1'b1;
            @(posedge clk);
            rdy <= 1'b0;
            fin();
         end else begin
            @(posedge clk);
            u_m.stop();
         end
      end
   endtask : t_table
   task automatic t_transmit();
      logic [7:0] b;
      int m0;
      wr(`TWS_ADDR_OWN, 8'h54);
      ack_en <= 1'b1;
      m0 = mcnt;
      u_m.start();
      u_m.send(8'h55, ack);
      `CHK("ack", 1'b0, ack)
      wait_flag(1'b1);
      `CHK("match", 1, mcnt - m0)
      chk_st(8'ha8);
      wr(`TWS_ADDR_DATA, 8'h96);
      clr();
      u_m.recv(1'b1, b);
      `CHK("tx", 8'h96, b)
      wait_flag(1'b1);
      chk_st(8'hc0);
      chk_rd("echo", `TWS_ADDR_DATA, 8'h96);
      clr();
      u_m.stop();
      wait_flag(1'b0);
   endtask : t_transmit
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_prescale();
      t_collide();
      t_receive();
      t_table();
      t_transmit();
      give_verdict();
   end
endmodule : testbench
